// >>> aro_defines.svh
// constants for the reset, power and averaging control block
// assumes a 125 MHz clock; included by bare name
`ifndef ARO_DEFINES_SVH
`define ARO_DEFINES_SVH

`define ARO_CLK_NS 8
`define ARO_PART_MIN_NS 55
`define ARO_PART_MIN_CYC ((`ARO_PART_MIN_NS + `ARO_CLK_NS - 1) / `ARO_CLK_NS)
`define ARO_PART_MAX_NS 2000
`define ARO_PART_MAX_CYC (`ARO_PART_MAX_NS / `ARO_CLK_NS)
`define ARO_FULL_MIN_NS 3000
`define ARO_FULL_MIN_CYC ((`ARO_FULL_MIN_NS + `ARO_CLK_NS - 1) / `ARO_CLK_NS)
`define ARO_CONV_NS 1000
`define ARO_CONV_CYC (`ARO_CONV_NS / `ARO_CLK_NS)
`define ARO_OS_PER_NS 1250
`define ARO_OS_PER_CYC (`ARO_OS_PER_NS / `ARO_CLK_NS)

`define ARO_ADDR_STATUS 8'h01
`define ARO_ADDR_CONFIG 8'h02
`define ARO_ADDR_RATIO 8'h08
`define ARO_STS_RSEEN_BIT 7
`define ARO_CFG_PWR_LSB 0
`define ARO_CFG_LINES_LSB 3
`define ARO_CFG_RST 8'h08
`define ARO_RATIO_RST 8'h00
`define ARO_RATIO_MAX 4'h8
`define ARO_PIN_LINES 2'h1
`define ARO_OS_SW_CODE 3'h7

`endif

// >>> aro_pkg.sv
// types shared by the reset, power and averaging control block
// assumes nothing of its surroundings
package aro_pkg;
  // order matches the two-bit power field encoding
  typedef enum logic [1:0] {ARO_NORMAL, ARO_STANDBY, ARO_AUTO, ARO_SHUTDOWN} aro_pwr_t;
  typedef enum logic {ARO_IDLE, ARO_RUN} aro_seq_t;
endpackage

// >>> aro_rst_classify.sv
// reset pin pulse width classifier
// assumes a synchronised reset pin level on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "aro_defines.svh"
module aro_rst_classify (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // synchronised reset pin
  input wire logic pin,
  // one-cycle pulses on release of the pin
  output logic part_p,
  output logic full_p
);
  logic [8:0] cnt_reg;
  logic pin_prev_reg;

  // width counted on the internal time base; saturates at the full threshold
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= 9'h000;
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= pin;
      if (pin) begin
        if (cnt_reg != 9'(`ARO_FULL_MIN_CYC)) begin
          cnt_reg <= cnt_reg + 9'h001;
        end
      end else if (!pin_prev_reg) begin
        cnt_reg <= 9'h000;
      end
    end
  end

  // widths between the partial maximum and the full minimum count as partial
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      part_p <= 1'b0;
      full_p <= 1'b0;
    end else begin
      part_p <= pin_prev_reg && !pin && cnt_reg >= 9'(`ARO_PART_MIN_CYC)
        && cnt_reg < 9'(`ARO_FULL_MIN_CYC);
      full_p <= pin_prev_reg && !pin && cnt_reg >= 9'(`ARO_FULL_MIN_CYC);
    end
  end

  part_class_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pin_prev_reg && !pin && cnt_reg >= 9'(`ARO_PART_MIN_CYC) && cnt_reg < 9'(`ARO_FULL_MIN_CYC))
    |=> part_p && !full_p)
    else $error("partial reset not recognised");
  full_class_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (pin_prev_reg && !pin && cnt_reg == 9'(`ARO_FULL_MIN_CYC)) |=> full_p && !part_p)
    else $error("full reset not recognised");
endmodule
`default_nettype wire

// >>> aro_os_seq.sv
// oversampling sequencer: first sample on start, the rest on an internal tick
// assumes start only arrives as a one-cycle pulse on the same clock
`timescale 1ns/1ns
`default_nettype none
`include "aro_defines.svh"
module aro_os_seq
  import aro_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic start,
  input wire logic abort,
  input wire logic [3:0] ratio,
  // status
  output logic busy,
  output logic sample_strobe,
  output logic done
);
  aro_seq_t state_reg;
  logic [8:0] left_reg;
  logic [8:0] tmr_reg;
  logic [17:0] len_reg;
  logic [17:0] want_reg;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ARO_IDLE;
      busy <= 1'b0;
      sample_strobe <= 1'b0;
      done <= 1'b0;
      left_reg <= 9'h000;
      tmr_reg <= 9'h000;
    end else begin
      sample_strobe <= 1'b0;
      done <= 1'b0;
      case (state_reg)
        ARO_IDLE: begin
          // starts while busy never reach here
          if (start && !abort) begin
            state_reg <= ARO_RUN;
            busy <= 1'b1;
            sample_strobe <= 1'b1;
            left_reg <= (9'h001 << ratio) - 9'h001;
            tmr_reg <= 9'h000;
          end
        end
        ARO_RUN: begin
          tmr_reg <= tmr_reg + 9'h001;
          if (abort) begin
            state_reg <= ARO_IDLE;
            busy <= 1'b0;
          end else if (left_reg != 9'h000 && tmr_reg == 9'(`ARO_OS_PER_CYC - 1)) begin
            sample_strobe <= 1'b1;
            left_reg <= left_reg - 9'h001;
            tmr_reg <= 9'h000;
          end else if (left_reg == 9'h000 && tmr_reg == 9'(`ARO_CONV_CYC - 1)) begin
            state_reg <= ARO_IDLE;
            busy <= 1'b0;
            done <= 1'b1;
          end
        end
        default: state_reg <= ARO_IDLE;
      endcase
    end
  end

  // helper: measured busy length against the expected extended time
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      len_reg <= 18'h00000;
      want_reg <= 18'h00000;
    end else if (state_reg == ARO_IDLE && start && !abort) begin
      // busy rises on this edge; counting starts with the first busy cycle
      len_reg <= 18'h00000;
      want_reg <= 18'(((18'h00001 << ratio) - 18'h00001) * 18'(`ARO_OS_PER_CYC) + 18'(`ARO_CONV_CYC));
    end else if (busy) begin
      len_reg <= len_reg + 18'h00001;
    end
  end

  busy_len_a: assert property (
    @(posedge clk) disable iff (!rst_n) done |-> len_reg == want_reg)
    else $error("busy length does not match averaged samples");
  abort_idle_a: assert property (
    @(posedge clk) disable iff (!rst_n) abort |=> !busy && !done)
    else $error("abort did not end conversion");
endmodule
`default_nettype wire

// >>> aro_ctrl.sv
// top of the reset, power-down and averaging control of an eight-channel converter
// assumes pins arrive asynchronously and the register port is driven on clk
//
// Functional notes
// - 55 ns to 2 us pulse is partial reset; the code treats every pulse from 56 ns to under 3 us as partial
// - pulse of 3 us or more is full
// - partial reset reinitialises filter, interfaces, converters, CRC
// - partial reset sets reset-seen status bit 7
// - partial drops result, keeps registers and straps
// - full reset restores defaults, flags, drops result
// - full reset release captures mode and interface
// - pin mode: standby pin, range choose power
// - register mode power field decodes four modes
// - leaving standby needs no reset
// - autostandby sleeps at busy fall, wakes on start
// - pin mode latches ratio pins at busy fall
// - register mode ratio from ratio register
// - first sample on start, rest internal
// - busy covers all averaged samples
// - two lines in pin mode, selectable otherwise
// - select pins 000 none, 001-110 ratios, 111 register
// - start raises busy; starts while busy ignored
`timescale 1ns/1ns
`default_nettype none
`include "aro_defines.svh"
module aro_ctrl
  import aro_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic nrst,
  // device pins
  input wire logic reset_pin,
  input wire logic conversion_start,
  input wire logic standby_pin_n,
  input wire logic range_pin,
  input wire logic [2:0] averaging_select_pins,
  input wire logic serial_select_pin,
  // register port from the readout interface
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // conversion control
  output logic busy,
  output logic sample_strobe,
  output logic result_ready,
  output logic result_discard,
  output logic reinit,
  // mode outputs
  output aro_pkg::aro_pwr_t power_state,
  output logic register_mode,
  output logic serial_iface,
  output logic [1:0] serial_lines,
  output logic [3:0] averaging_ratio_code
);
  import aro_pkg::*;

  logic [1:0] rst_sync_reg;
  logic rst_n;
  logic [7:0] pin_s1_reg;
  logic [7:0] pin_s2_reg;
  logic rstp;
  logic cs;
  logic standby_pin_n_n;
  logic range_lvl;
  logic [2:0] os_pins;
  logic ser_sel;
  logic cs_prev_reg;
  logic cs_rise;
  logic busy_prev_reg;
  logic busy_fall;
  logic part_p;
  logic full_p;
  logic [1:0] init_cnt_reg;
  logic capture;
  logic [7:0] cfg_reg;
  logic [7:0] ratio_reg;
  logic rseen_reg;
  logic [2:0] pin_ratio_reg;
  logic auto_sleep_reg;
  aro_pwr_t mode_sel;
  aro_pwr_t pwr_next;
  logic start;
  logic abort;
  logic wr_ok;
  logic [3:0] ratio_next;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_reg[1];

  // all pins pass two flops before any logic looks at them
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_s1_reg <= 8'h00;
      pin_s2_reg <= 8'h00;
    end else begin
      pin_s1_reg <= {reset_pin, conversion_start, standby_pin_n, range_pin,
                     averaging_select_pins, serial_select_pin};
      pin_s2_reg <= pin_s1_reg;
    end
  end
  assign rstp = pin_s2_reg[7];
  assign cs = pin_s2_reg[6];
  assign standby_pin_n_n = pin_s2_reg[5];
  assign range_lvl = pin_s2_reg[4];
  assign os_pins = pin_s2_reg[3:1];
  assign ser_sel = pin_s2_reg[0];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_prev_reg <= 1'b0;
      busy_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg <= cs;
      busy_prev_reg <= busy;
    end
  end
  assign cs_rise = cs && !cs_prev_reg;
  assign busy_fall = busy_prev_reg && !busy;

  aro_rst_classify u_classify (
    .clk(clk),
    .rst_n(rst_n),
    .pin(rstp),
    .part_p(part_p),
    .full_p(full_p)
  );

  // power-on acts as a full reset release, but only once the pin synchronisers hold real levels
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      init_cnt_reg <= 2'h0;
    end else if (init_cnt_reg != 2'h3) begin
      init_cnt_reg <= init_cnt_reg + 2'h1;
    end
  end
  assign capture = full_p || (init_cnt_reg == 2'h2);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      register_mode <= 1'b0;
      serial_iface <= 1'b0;
    end else if (capture) begin
      register_mode <= (os_pins == `ARO_OS_SW_CODE);
      serial_iface <= ser_sel;
    end
  end

  // registers ignore writes while the reset pin is held
  assign wr_ok = reg_wr && !rstp;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cfg_reg <= `ARO_CFG_RST;
      ratio_reg <= `ARO_RATIO_RST;
    end else if (full_p) begin
      cfg_reg <= `ARO_CFG_RST;
      ratio_reg <= `ARO_RATIO_RST;
    end else if (wr_ok) begin
      // partial reset leaves these alone
      if (reg_addr == `ARO_ADDR_CONFIG) begin
        cfg_reg <= reg_wdata;
      end
      if (reg_addr == `ARO_ADDR_RATIO) begin
        ratio_reg <= reg_wdata;
      end
    end
  end

  // write-one clears; a reset in the same cycle keeps the flag set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rseen_reg <= 1'b1;
    end else if (part_p || full_p) begin
      rseen_reg <= 1'b1;
    end else if (wr_ok && reg_addr == `ARO_ADDR_STATUS && reg_wdata[`ARO_STS_RSEEN_BIT]) begin
      rseen_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `ARO_ADDR_STATUS: reg_rdata <= {rseen_reg, 7'h00};
        `ARO_ADDR_CONFIG: reg_rdata <= cfg_reg;
        `ARO_ADDR_RATIO: reg_rdata <= ratio_reg;
        default: reg_rdata <= 8'h00;
      endcase
    end
  end

  // ratio pins are only sampled between conversions, so a change mid-burst waits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pin_ratio_reg <= 3'h0;
    end else if (capture || (busy_fall && !register_mode)) begin
      pin_ratio_reg <= os_pins;
    end
  end

  always_comb begin
    ratio_next = {1'b0, pin_ratio_reg};
    if (register_mode) begin
      ratio_next = (ratio_reg[3:0] > `ARO_RATIO_MAX) ? `ARO_RATIO_MAX : ratio_reg[3:0];
    end else if (pin_ratio_reg == `ARO_OS_SW_CODE) begin
      ratio_next = 4'h0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      averaging_ratio_code <= 4'h0;
      serial_lines <= `ARO_PIN_LINES;
    end else begin
      averaging_ratio_code <= ratio_next;
      serial_lines <= register_mode ? cfg_reg[`ARO_CFG_LINES_LSB +: 2] : `ARO_PIN_LINES;
    end
  end

  always_comb begin
    if (register_mode) begin
      mode_sel = aro_pwr_t'(cfg_reg[`ARO_CFG_PWR_LSB +: 2]);
    end else if (standby_pin_n_n) begin
      mode_sel = ARO_NORMAL;
    end else begin
      mode_sel = range_lvl ? ARO_STANDBY : ARO_SHUTDOWN;
    end
  end

  // autostandby: sleep after each burst, wake on the next start edge
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      auto_sleep_reg <= 1'b0;
    end else if (mode_sel != ARO_AUTO) begin
      auto_sleep_reg <= 1'b0;
    end else if (busy_fall) begin
      auto_sleep_reg <= 1'b1;
    end else if (cs_rise) begin
      auto_sleep_reg <= 1'b0;
    end
  end

  always_comb begin
    case (mode_sel)
      ARO_STANDBY: pwr_next = ARO_STANDBY;
      ARO_SHUTDOWN: pwr_next = ARO_SHUTDOWN;
      ARO_AUTO: pwr_next = (auto_sleep_reg && !cs_rise) || busy_fall ? ARO_STANDBY : ARO_NORMAL;
      default: pwr_next = ARO_NORMAL;
    endcase
  end

  // leaving standby simply returns to normal, no reset involved
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      power_state <= ARO_NORMAL;
    end else begin
      power_state <= pwr_next;
    end
  end

  // the start edge is honoured in normal and autostandby only
  assign start = cs_rise && !rstp && !busy && (mode_sel == ARO_NORMAL || mode_sel == ARO_AUTO);
  assign abort = part_p || full_p;

  aro_os_seq u_seq (
    .clk(clk),
    .rst_n(rst_n),
    .start(start),
    .abort(abort),
    .ratio(ratio_next),
    .busy(busy),
    .sample_strobe(sample_strobe),
    .done(result_ready)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      result_discard <= 1'b0;
      reinit <= 1'b0;
    end else begin
      result_discard <= abort;
      reinit <= abort;
    end
  end

  reset_seen_a: assert property (
    @(posedge clk) disable iff (!rst_n) part_p |=> rseen_reg)
    else $error("reset-seen not reported");
  partial_keep_a: assert property (
    @(posedge clk) disable iff (!rst_n) (part_p && !wr_ok) |=> $stable(cfg_reg) && $stable(ratio_reg))
    else $error("partial reset altered registers");
  full_default_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    full_p |=> cfg_reg == `ARO_CFG_RST && ratio_reg == `ARO_RATIO_RST && !busy && result_discard)
    else $error("full reset did not restore defaults");
  strap_capture_a: assert property (
    @(posedge clk) disable iff (!rst_n) full_p |=> register_mode == ($past(os_pins) == `ARO_OS_SW_CODE))
    else $error("mode strap not captured");
  pin_power_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!register_mode && !standby_pin_n_n && !range_lvl) |=> power_state == ARO_SHUTDOWN)
    else $error("shutdown not entered from pins");
  auto_sleep_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (mode_sel == ARO_AUTO && busy_fall) |=> power_state == ARO_STANDBY)
    else $error("autostandby did not sleep after busy");
  ratio_latch_a: assert property (
    @(posedge clk) disable iff (!rst_n)
    (!register_mode && busy_fall && !capture) |=> pin_ratio_reg == $past(os_pins))
    else $error("ratio pins not latched at busy fall");
  start_busy_a: assert property (
    @(posedge clk) disable iff (!rst_n) start |=> busy && sample_strobe)
    else $error("start did not raise busy");
endmodule
`default_nettype wire

// >>> aro_host_model.sv
// host controller model: drives the reset, start, standby and strap pins
// assumes the device synchronises every pin to clk itself
`timescale 1ns/1ns
`default_nettype none
module aro_host_model #(
  parameter int PWRUP_CYC = 1250000
) (
  // clock
  input wire logic clk,
  // device pins
  output var logic reset_pin,
  output var logic conversion_start,
  output var logic standby_pin_n,
  output var logic range_pin,
  output var logic [2:0] averaging_select_pins,
  output var logic serial_select_pin
);
  initial begin
    reset_pin = 1'b0;
    conversion_start = 1'b0;
    standby_pin_n = 1'b1;
    range_pin = 1'b1;
    averaging_select_pins = 3'h0;
    serial_select_pin = 1'b1;
  end

  // setup waits of 56 ns and 253 us, counted in 8 ns cycles
  task automatic pulse_reset(input int len, input bit full);
    @(posedge clk);
    reset_pin <= 1'b1;
    repeat (len) @(posedge clk);
    reset_pin <= 1'b0;
    repeat (full ? 31625 : 7) @(posedge clk);
  endtask

  // low for 130 cycles, just over the 1 us wake-up, which also spaces starts apart
  task automatic start(input bit retrig);
    @(posedge clk);
    conversion_start <= 1'b0;
    repeat (130) @(posedge clk);
    conversion_start <= 1'b1;
    if (retrig) begin
      repeat (40) @(posedge clk);
      conversion_start <= 1'b0;
      repeat (20) @(posedge clk);
      conversion_start <= 1'b1;
    end
  endtask

  task automatic set_pins(input logic standby_pin_n_n, input logic rng, input logic [2:0] os, input logic ser);
    @(posedge clk);
    standby_pin_n <= standby_pin_n_n;
    range_pin <= rng;
    averaging_select_pins <= os;
    serial_select_pin <= ser;
  endtask

  // power-up wait, then the full reset that shutdown exit demands
  task automatic leave_shutdown(input logic [2:0] os, input logic ser);
    set_pins(1'b1, range_pin, os, ser);
    repeat (PWRUP_CYC) @(posedge clk);
    pulse_reset(400, 1'b1);
  endtask
endmodule
`default_nettype wire

// >>> aro_ctrl_tb.sv
// self-checking bench for the reset, power-down and averaging control
// assumes the host model owns the device pins and the bench owns the register port
`timescale 1ns/1ns
`default_nettype none
module aro_ctrl_tb;
  import aro_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic reset_pin, conversion_start, standby_pin_n, range_pin, serial_select_pin;
  logic [2:0] averaging_select_pins;
  logic [7:0] reg_rdata;
  logic busy, sample_strobe, result_ready, result_discard, reinit, register_mode, serial_iface;
  logic [1:0] serial_lines;
  logic [3:0] averaging_ratio_code;
  aro_pwr_t power_state;
  aro_pwr_t ps_busy;
  int failures = 0;
  int num_checks = 0;
  int nb, ns, nr, nd, ni;

  always #4 clk = ~clk;

  // power-up wait shortened: the device does not time it
  aro_host_model #(.PWRUP_CYC(500)) i_aro_host_model (.clk(clk), .reset_pin(reset_pin),
    .conversion_start(conversion_start), .standby_pin_n(standby_pin_n), .range_pin(range_pin),
    .averaging_select_pins(averaging_select_pins), .serial_select_pin(serial_select_pin));

  aro_ctrl i_aro_ctrl (.clk(clk), .nrst(nrst), .reset_pin(reset_pin), .conversion_start(conversion_start),
    .standby_pin_n(standby_pin_n), .range_pin(range_pin), .averaging_select_pins(averaging_select_pins),
    .serial_select_pin(serial_select_pin), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .busy(busy), .sample_strobe(sample_strobe),
    .result_ready(result_ready), .result_discard(result_discard), .reinit(reinit),
    .power_state(power_state), .register_mode(register_mode), .serial_iface(serial_iface),
    .serial_lines(serial_lines), .averaging_ratio_code(averaging_ratio_code));

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic reg_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    chk($sformatf("register %h", a), 16'(exp), 16'(reg_rdata));
  endtask

  task automatic measure();
    int w;
    nb = 0;
    ns = 0;
    nd = 0;
    ni = 0;
    for (w = 0; w < 400 && busy !== 1'b1; w++) @(posedge clk);
    ps_busy = power_state;
    while (busy === 1'b1 && nb < 50000) begin
      nb++;
      ns += int'(sample_strobe === 1'b1);
      nd += int'(result_discard === 1'b1);
      ni += int'(reinit === 1'b1);
      @(posedge clk);
    end
    nr = int'(result_ready === 1'b1);
    nd += int'(result_discard === 1'b1);
    ni += int'(reinit === 1'b1);
  endtask

  task automatic conv(input bit retrig, input int rst_len);
    fork
      i_aro_host_model.start(retrig);
      if (rst_len > 0) begin
        repeat (170) @(posedge clk);
        i_aro_host_model.pulse_reset(rst_len, 1'b0);
      end
      measure();
    join
  endtask

  task automatic chk_conv(input int n);
    int exp;
    exp = (n - 1) * 156 + 125;
    chk("busy cycles", exp[15:0], nb[15:0]);
    chk("sample strobes", n[15:0], ns[15:0]);
    chk("result ready", 16'h1, nr[15:0]);
  endtask

  initial begin
    repeat (100000) @(posedge clk);
    failures++;
    $display("mismatch watchdog expected finish seen timeout");
    report_and_stop();
  end

  initial begin
    int k;
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    repeat (8) @(posedge clk);
    chk("register_mode", 16'h0, 16'(register_mode));
    chk("serial_iface", 16'h1, 16'(serial_iface));
    chk("serial_lines", 16'h1, 16'(serial_lines));
    reg_check(8'h01, 8'h80);
    reg_check(8'h02, 8'h08);
    reg_check(8'h08, 8'h00);
    reg_check(8'h05, 8'h00);
    reg_write(8'h01, 8'h80);
    reg_check(8'h01, 8'h00);
    $display("test registers done");
    for (k = 0; k < 7; k++) begin
      i_aro_host_model.set_pins(1'b1, 1'b1, 3'((k + 1) % 7), 1'b1);
      conv(k == 0, 0);
      chk_conv(1 << k);
      repeat (2) @(posedge clk);
      chk("averaging_ratio_code", 16'((k + 1) % 7), 16'(averaging_ratio_code));
    end
    $display("test pin ratios done");
    reg_write(8'h08, 8'h35);
    conv(0, 4);
    chk_conv(1);
    chk("result_discard", 16'h0, nd[15:0]);
    conv(0, 20);
    chk("result_discard", 16'h1, nd[15:0]);
    chk("reinit", 16'h1, ni[15:0]);
    chk("result ready", 16'h0, nr[15:0]);
    reg_check(8'h01, 8'h80);
    reg_check(8'h08, 8'h35);
    $display("test partial reset done");
    i_aro_host_model.set_pins(1'b0, 1'b1, 3'h0, 1'b1);
    repeat (6) @(posedge clk);
    chk("power_state", 16'(ARO_STANDBY), 16'(power_state));
    conv(0, 0);
    chk("refused start", 16'h0, nb[15:0]);
    i_aro_host_model.set_pins(1'b1, 1'b1, 3'h0, 1'b1);
    conv(0, 0);
    chk_conv(1);
    reg_write(8'h02, 8'h13);
    reg_check(8'h02, 8'h13);
    i_aro_host_model.set_pins(1'b0, 1'b0, 3'h0, 1'b1);
    repeat (6) @(posedge clk);
    chk("power_state", 16'(ARO_SHUTDOWN), 16'(power_state));
    i_aro_host_model.leave_shutdown(3'h7, 1'b0);
    chk("register_mode", 16'h1, 16'(register_mode));
    chk("serial_iface", 16'h0, 16'(serial_iface));
    reg_check(8'h01, 8'h80);
    reg_check(8'h02, 8'h08);
    reg_check(8'h08, 8'h00);
    $display("test pin power and full reset done");
    reg_write(8'h08, 8'h03);
    conv(0, 0);
    chk_conv(8);
    reg_write(8'h08, 8'h07);
    repeat (2) @(posedge clk);
    chk("averaging_ratio_code", 16'h7, 16'(averaging_ratio_code));
    reg_write(8'h08, 8'h0f);
    repeat (2) @(posedge clk);
    chk("averaging_ratio_code", 16'h8, 16'(averaging_ratio_code));
    reg_write(8'h08, 8'h00);
    reg_write(8'h02, 8'h02);
    conv(0, 0);
    chk_conv(1);
    chk("serial_lines", 16'h0, 16'(serial_lines));
    repeat (2) @(posedge clk);
    chk("power_state", 16'(ARO_STANDBY), 16'(power_state));
    conv(0, 0);
    chk("power_state", 16'(ARO_NORMAL), 16'(ps_busy));
    chk_conv(1);
    for (k = 0; k < 4; k++) begin
      reg_write(8'h02, 8'h10 | 8'(k));
      repeat (3) @(posedge clk);
      chk("power_state", 16'((k == 2) ? 0 : k), 16'(power_state));
      chk("serial_lines", 16'h2, 16'(serial_lines));
    end
    $display("test register mode done");
    report_and_stop();
  end
endmodule
`default_nettype wire
